// [clock_prescale_defines.svh]
// clock_prescale_defines.svh: register offsets, field positions, reset values and
// timing counts for the clock prescaler and sleep controller.
// assumes inclusion by bare name; definitions only, no logic.
`ifndef CLOCK_PRESCALE_DEFINES_SVH
`define CLOCK_PRESCALE_DEFINES_SVH

// bus geometry and register word indexes (byte address is four times the index)
`define REG_ADDR_W 8
`define CLK_DIV_CTRL_IDX 6'h00
`define MCU_CTRL_IDX 6'h01
`define MCU_STATUS_IDX 6'h02
`define EXT_MCU_CTRL_IDX 6'h03
`define POWER_STATUS_IDX 6'h04
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// field positions
`define UNLOCK_BIT 7
`define SLEEP_ARM_BIT 5
`define KIND_BIT1_POS 4
`define KIND_BIT2_POS 5
`define KIND_BIT0_POS 7

// reset values and the highest legal select code
`define SELECT_RESET_PLAIN 4'h0
`define SELECT_RESET_DIV8 4'h3
`define SELECT_MAX 4'h8
`define MCU_CTRL_RESET 8'h00
`define MCU_STATUS_RESET 8'h00
`define EXT_MCU_CTRL_RESET 8'h00

// timing counts in system clock cycles
`define UNLOCK_WINDOW_CYCLES 3'h4
`define WAKE_HALT_CYCLES 8'h04
`define STANDBY_START_CYCLES 8'h06
`define POWER_DOWN_START_CYCLES 8'h06

`endif

// [clock_prescale_pkg.sv]
// clock_prescale_pkg: types and small decoders for the prescaler and sleep controller.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package clock_prescale_pkg;

  // gray along run -> sleep -> wake
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WAKE = 2'h3
  } sleep_state_t;

  typedef enum logic [2:0] {
    KIND_IDLE = 3'h0,
    KIND_POWER_DOWN = 3'h2,
    KIND_POWER_SAVE = 3'h3,
    KIND_STANDBY = 3'h6,
    KIND_EXT_STANDBY = 3'h7
  } sleep_kind_t;

  // terminal count of the divider: factor minus one
  function automatic logic [7:0] divide_mask(input logic [3:0] sel);
    logic [8:0] factor;
    factor = 9'h001 << sel;
    divide_mask = (sel > 4'h8) ? 8'hFF : 8'(factor - 9'h001);
  endfunction : divide_mask

  // reserved sleep kinds are never entered
  function automatic logic kind_legal(input logic [2:0] kind);
    kind_legal = (kind == 3'h0) || (kind == 3'h2) || (kind == 3'h3) ||
                 (kind == 3'h6) || (kind == 3'h7);
  endfunction : kind_legal

endpackage : clock_prescale_pkg

`default_nettype wire

// [clock_divide_tick.sv]
// clock_divide_tick: turns the divide-select code into a one-cycle enable pulse.
// assumes the select code is already legal (0..8) and on the same clock.
`default_nettype none

module clock_divide_tick (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] divide_select_i,
  output logic tick_o
);

  logic [7:0] count_reg;
  logic [7:0] mask;
  logic tick_reg;

  assign mask = clock_prescale_pkg::divide_mask(divide_select_i);
  assign tick_o = tick_reg;

  // free counter; >= so a runtime drop to a smaller factor wraps at once
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      count_reg <= 8'h00;
    end else if (count_reg >= mask) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // registered pulse, one per factor cycles
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (count_reg >= mask);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_undivided;
    divide_select_i == 4'h0 |=> tick_o;
  endproperty
  a_undivided: assert property (p_undivided) else $error("factor one must tick every cycle");

  property p_divided_gap;
    tick_o && divide_select_i != 4'h0 |=> !tick_o;
  endproperty
  a_divided_gap: assert property (p_divided_gap) else $error("divided tick not spaced");

endmodule : clock_divide_tick

`default_nettype wire

// [clock_prescale_sleep_ctrl.sv]
// clock_prescale_sleep_ctrl: system clock prescaler with timed unlock, and sleep
// entry and wake sequencing, behind an AXI4-Lite register slave.
// assumes core strobes (sleep_instr_i, irq_pending_i, timer_async_i) on sys_clk_i;
// the fuse input is a pin and is synchronised here.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`include "clock_prescale_defines.svh"
`default_nettype none

module clock_prescale_sleep_ctrl #(
  parameter logic [7:0] STARTUP_CYCLES = `POWER_DOWN_START_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic divide_by_eight_fuse_i,
  input wire logic sleep_instr_i,
  input wire logic irq_pending_i,
  input wire logic timer_async_i,
  output logic cpu_clk_en_o,
  output logic io_clk_en_o,
  output logic asy_clk_en_o,
  output logic main_osc_en_o,
  output logic irq_block_o,
  output logic wake_irq_o,
  output logic sleeping_o
);

  // word index lies inside the map
  function automatic logic addr_mapped(input logic [5:0] idx);
    addr_mapped = (idx <= `POWER_STATUS_IDX);
  endfunction : addr_mapped

  logic fuse_meta_reg;
  logic fuse_sync_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb_low_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic do_write;
  logic [5:0] wr_idx;
  logic cdc_wr;
  logic [31:0] read_word;
  logic [3:0] select_reg;
  logic unlock_reg;
  logic [2:0] unlock_count_reg;
  logic [3:0] new_select;
  logic [7:0] mcu_ctrl_reg;
  logic [7:0] mcu_status_reg;
  logic [7:0] ext_ctrl_reg;
  logic [2:0] kind_sel;
  logic sleep_arm;
  clock_prescale_pkg::sleep_state_t state_reg;
  clock_prescale_pkg::sleep_kind_t sleep_kind_reg;
  logic [7:0] wake_count_reg;
  logic [7:0] wake_total;
  logic wake_irq_reg;
  logic div_tick;
  logic sleep_go;
  logic wake_go;
  logic asleep_deep;
  logic asy_active;

  // fuse is a pin: two stages, no reset so the value is settled when reset loads it
  always_ff @(posedge sys_clk_i) begin
    fuse_meta_reg <= divide_by_eight_fuse_i;
    fuse_sync_reg <= fuse_meta_reg;
  end

  // write channel: address and data latched independently, either order
  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = awaddr_reg[7:2];
  assign cdc_wr = do_write && wstrb_low_reg && (wr_idx == `CLK_DIV_CTRL_IDX);
  assign new_select = wdata_reg[3:0];

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // only byte lane 0 carries register data
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb_low_reg <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata_i[7:0];
      wstrb_low_reg <= s_axi_wstrb_i[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // write response raised on the same edge the write lands
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // read data word for the presented address
  always_comb begin
    read_word = 32'h0000_0000;
    case (s_axi_araddr_i[7:2])
      `CLK_DIV_CTRL_IDX: read_word = {24'h00_0000, unlock_reg, 3'h0, select_reg};
      `MCU_CTRL_IDX: read_word = {24'h00_0000, mcu_ctrl_reg};
      `MCU_STATUS_IDX: read_word = {24'h00_0000, mcu_status_reg};
      `EXT_MCU_CTRL_IDX: read_word = {24'h00_0000, ext_ctrl_reg};
      `POWER_STATUS_IDX: read_word = {27'h000_0000, sleep_kind_reg,
                                     state_reg == clock_prescale_pkg::ST_WAKE,
                                     state_reg != clock_prescale_pkg::ST_RUN};
      default: read_word = 32'h0000_0000;
    endcase
  end

  // read channel: one outstanding read, data held until taken
  assign s_axi_arready_o = !rvalid_reg;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= read_word;
      rresp_reg <= addr_mapped(s_axi_araddr_i[7:2]) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;

  // timed unlock then value write; a write while locked only may unlock
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      select_reg <= fuse_sync_reg ? `SELECT_RESET_DIV8 : `SELECT_RESET_PLAIN;
      unlock_reg <= 1'b0;
      unlock_count_reg <= 3'h0;
    end else if (cdc_wr && unlock_reg) begin
      unlock_reg <= 1'b0;
      if (!wdata_reg[`UNLOCK_BIT] && new_select <= `SELECT_MAX) begin
        select_reg <= new_select;
      end
    end else if (cdc_wr) begin
      if (wdata_reg[`UNLOCK_BIT] && wdata_reg[6:0] == 7'h00) begin
        unlock_reg <= 1'b1;
        unlock_count_reg <= `UNLOCK_WINDOW_CYCLES;
      end
    end else if (unlock_reg) begin
      if (unlock_count_reg == 3'h1) begin
        unlock_reg <= 1'b0;
      end
      unlock_count_reg <= unlock_count_reg - 3'h1;
    end
  end

  // interrupts held off for the whole unlock window
  assign irq_block_o = unlock_reg;

  // plain storage registers; sleep logic never writes them
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mcu_ctrl_reg <= `MCU_CTRL_RESET;
      mcu_status_reg <= `MCU_STATUS_RESET;
      ext_ctrl_reg <= `EXT_MCU_CTRL_RESET;
    end else if (do_write && wstrb_low_reg) begin
      if (wr_idx == `MCU_CTRL_IDX) begin
        mcu_ctrl_reg <= wdata_reg;
      end
      if (wr_idx == `MCU_STATUS_IDX) begin
        mcu_status_reg <= wdata_reg;
      end
      if (wr_idx == `EXT_MCU_CTRL_IDX) begin
        ext_ctrl_reg <= wdata_reg;
      end
    end
  end

  // kind gathered from three registers
  assign kind_sel = {mcu_status_reg[`KIND_BIT2_POS], mcu_ctrl_reg[`KIND_BIT1_POS],
                     ext_ctrl_reg[`KIND_BIT0_POS]};
  assign sleep_arm = mcu_ctrl_reg[`SLEEP_ARM_BIT];
  assign sleep_go = sleep_instr_i && sleep_arm && clock_prescale_pkg::kind_legal(kind_sel);
  // a wake cannot slip in while the unlock window is open
  assign wake_go = irq_pending_i && !unlock_reg;

  // start-up time per kind plus the fixed halt
  always_comb begin
    wake_total = `WAKE_HALT_CYCLES;
    unique case (sleep_kind_reg)
      clock_prescale_pkg::KIND_IDLE: wake_total = `WAKE_HALT_CYCLES;
      clock_prescale_pkg::KIND_STANDBY,
      clock_prescale_pkg::KIND_EXT_STANDBY:
        wake_total = 8'(`STANDBY_START_CYCLES + `WAKE_HALT_CYCLES);
      clock_prescale_pkg::KIND_POWER_DOWN,
      clock_prescale_pkg::KIND_POWER_SAVE:
        wake_total = 8'(STARTUP_CYCLES + `WAKE_HALT_CYCLES);
      default: wake_total = `WAKE_HALT_CYCLES;
    endcase
  end

  // sleep sequencer; reset always lands in run, i.e. at the reset vector
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= clock_prescale_pkg::ST_RUN;
      sleep_kind_reg <= clock_prescale_pkg::KIND_IDLE;
    end else begin
      unique case (state_reg)
        clock_prescale_pkg::ST_RUN: begin
          if (sleep_go) begin
            state_reg <= clock_prescale_pkg::ST_SLEEP;
            sleep_kind_reg <= clock_prescale_pkg::sleep_kind_t'(kind_sel);
          end
        end
        clock_prescale_pkg::ST_SLEEP: begin
          if (wake_go) begin
            state_reg <= clock_prescale_pkg::ST_WAKE;
          end
        end
        clock_prescale_pkg::ST_WAKE: begin
          if (wake_count_reg == 8'h01) begin
            state_reg <= clock_prescale_pkg::ST_RUN;
          end
        end
        default: state_reg <= clock_prescale_pkg::ST_RUN;
      endcase
    end
  end

  // halt counter loaded at the wake event
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wake_count_reg <= 8'h00;
    end else if (state_reg == clock_prescale_pkg::ST_SLEEP && wake_go) begin
      wake_count_reg <= wake_total;
    end else if (state_reg == clock_prescale_pkg::ST_WAKE) begin
      wake_count_reg <= wake_count_reg - 8'h01;
    end
  end

  // handler pulse in the first running cycle, before the next instruction
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wake_irq_reg <= 1'b0;
    end else begin
      wake_irq_reg <= (state_reg == clock_prescale_pkg::ST_WAKE) && (wake_count_reg == 8'h01);
    end
  end

  assign wake_irq_o = wake_irq_reg;
  assign sleeping_o = (state_reg != clock_prescale_pkg::ST_RUN);

  clock_divide_tick u_divide (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .divide_select_i(select_reg),
    .tick_o(div_tick)
  );

  // clock gating per sleep kind; idle keeps io, deep kinds stop it
  assign asleep_deep = (state_reg == clock_prescale_pkg::ST_SLEEP) &&
                       (sleep_kind_reg != clock_prescale_pkg::KIND_IDLE);
  assign asy_active = !asleep_deep ||
                      (sleep_kind_reg == clock_prescale_pkg::KIND_POWER_SAVE) ||
                      (sleep_kind_reg == clock_prescale_pkg::KIND_EXT_STANDBY);
  assign cpu_clk_en_o = div_tick && (state_reg == clock_prescale_pkg::ST_RUN);
  assign io_clk_en_o = div_tick && !asleep_deep;
  // an asynchronously clocked timer keeps its own rate, so only a level enable
  assign asy_clk_en_o = asy_active && (timer_async_i || div_tick);
  assign main_osc_en_o = !asleep_deep ||
                         (sleep_kind_reg == clock_prescale_pkg::KIND_STANDBY) ||
                         (sleep_kind_reg == clock_prescale_pkg::KIND_EXT_STANDBY);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_wake_idle;
    state_reg == clock_prescale_pkg::ST_SLEEP && wake_go &&
    sleep_kind_reg == clock_prescale_pkg::KIND_IDLE;
  endsequence

  sequence s_wake_standby;
    state_reg == clock_prescale_pkg::ST_SLEEP && wake_go &&
    sleep_kind_reg == clock_prescale_pkg::KIND_STANDBY;
  endsequence

  sequence s_resume;
    state_reg == clock_prescale_pkg::ST_RUN && wake_irq_o;
  endsequence

  property p_unlock_life;
    $rose(unlock_reg) |-> ##4 !unlock_reg;
  endproperty
  a_unlock_life: assert property (p_unlock_life) else $error("unlock not cleared in window");

  property p_select_locked;
    !unlock_reg |=> $stable(select_reg);
  endproperty
  a_select_locked: assert property (p_select_locked) else $error("select moved while locked");

  property p_value_taken;
    cdc_wr && unlock_reg && !wdata_reg[`UNLOCK_BIT] && new_select <= `SELECT_MAX
      |=> select_reg == $past(new_select) && !unlock_reg;
  endproperty
  a_value_taken: assert property (p_value_taken) else $error("unlocked value not taken");

  property p_reserved_select;
    cdc_wr && new_select > `SELECT_MAX |=> $stable(select_reg);
  endproperty
  a_reserved_select: assert property (p_reserved_select) else $error("reserved code taken");

  property p_fuse_reset;
    disable iff (1'b0) reset_i && fuse_sync_reg |=> select_reg == `SELECT_RESET_DIV8;
  endproperty
  a_fuse_reset: assert property (p_fuse_reset) else $error("fuse reset value wrong");

  property p_irq_held;
    state_reg == clock_prescale_pkg::ST_SLEEP && unlock_reg |-> irq_block_o
      ##1 state_reg == clock_prescale_pkg::ST_SLEEP;
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("wake during unlock window");

  property p_sleep_entry;
    state_reg == clock_prescale_pkg::ST_RUN && sleep_instr_i
      |=> (state_reg == clock_prescale_pkg::ST_SLEEP) == $past(sleep_go);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

  property p_wake_idle;
    s_wake_idle |=> (state_reg == clock_prescale_pkg::ST_WAKE)[*4] ##1 s_resume;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("idle wake halt not four");

  property p_wake_standby;
    s_wake_standby |=> (state_reg == clock_prescale_pkg::ST_WAKE)[*8]
      ##1 (state_reg == clock_prescale_pkg::ST_WAKE)[*2] ##1 s_resume;
  endproperty
  a_wake_standby: assert property (p_wake_standby) else $error("standby wake not ten");

  property p_power_down;
    state_reg == clock_prescale_pkg::ST_SLEEP &&
    sleep_kind_reg == clock_prescale_pkg::KIND_POWER_DOWN
      |-> !cpu_clk_en_o && !io_clk_en_o && !asy_clk_en_o && !main_osc_en_o;
  endproperty
  a_power_down: assert property (p_power_down) else $error("clock alive in power-down");

  property p_idle_clocks;
    state_reg == clock_prescale_pkg::ST_SLEEP && sleep_kind_reg == clock_prescale_pkg::KIND_IDLE
      |-> !cpu_clk_en_o && main_osc_en_o && io_clk_en_o == div_tick;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle gating wrong");

  property p_regs_kept;
    state_reg != clock_prescale_pkg::ST_RUN && !do_write
      |=> $stable(mcu_ctrl_reg) && $stable(mcu_status_reg) && $stable(ext_ctrl_reg);
  endproperty
  a_regs_kept: assert property (p_regs_kept) else $error("register lost in sleep");

  property p_reset_sleep;
    disable iff (1'b0) reset_i |=> state_reg == clock_prescale_pkg::ST_RUN && !wake_irq_o;
  endproperty
  a_reset_sleep: assert property (p_reset_sleep) else $error("reset did not restart");

  property p_cdc_read;
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] == `CLK_DIV_CTRL_IDX
      |=> s_axi_rvalid_o && s_axi_rdata_o[6:4] == 3'h0 && s_axi_rdata_o[31:8] == 24'h00_0000;
  endproperty
  a_cdc_read: assert property (p_cdc_read) else $error("reserved bits not zero");

  property p_asy_scaled;
    !timer_async_i && asy_clk_en_o |-> div_tick;
  endproperty
  a_asy_scaled: assert property (p_asy_scaled) else $error("sync timer clock unscaled");

endmodule : clock_prescale_sleep_ctrl

`default_nettype wire

// [clock_prescale_sleep_ctrl_tb.sv]
// clock_prescale_sleep_ctrl_tb: register-level bench for the prescaler and sleep control.
// assumes the design files and clock_prescale_defines.svh compile alongside.
`include "clock_prescale_defines.svh"
`default_nettype none
module clock_prescale_sleep_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] STARTUP = 8'h03;
  logic clk = 1'b0, rst = 1'b1, fuse = 1'b1, aw_valid = 1'b0, w_valid = 1'b0, ar_valid = 1'b0;
  logic sleep_instr = 1'b0, irq = 1'b0, tmr_async = 1'b0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0, r_data, rdat;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, cpu_en, io_en, asy_en, osc_en;
  logic irq_blk, wake_irq, sleeping;
  logic [1:0] b_resp, r_resp, resp;
  int n_errors = 0, checks_done = 0, cyc = 0, n_cpu, n_io, n_asy;
  logic [2:0] kinds [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  int waits [5] = '{4, STARTUP + 4, STARTUP + 4, 10, 10};
  // bready/rready held high and only byte lane 0 used: three tied inputs
  clock_prescale_sleep_ctrl #(.STARTUP_CYCLES(STARTUP)) u_dut (.sys_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
    .s_axi_rvalid_o(r_valid), .s_axi_rready_i(1'b1), .divide_by_eight_fuse_i(fuse),
    .sleep_instr_i(sleep_instr), .irq_pending_i(irq), .timer_async_i(tmr_async),
    .cpu_clk_en_o(cpu_en), .io_clk_en_o(io_en), .asy_clk_en_o(asy_en), .main_osc_en_o(osc_en),
    .irq_block_o(irq_blk), .wake_irq_o(wake_irq), .sleeping_o(sleeping));
  always #4 clk = ~clk;
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // wr and rd start and end just after a rising edge; handshakes judged at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ad, wd, ta, tw;
    ad = 1'b0;
    wd = 1'b0;
    aw_addr <= a;
    w_data <= {24'h0, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ta = !ad && aw_ready === 1'b1;
      tw = !wd && w_ready === 1'b1;
      @(posedge clk);
      if (ta) aw_valid <= 1'b0;
      if (tw) w_valid <= 1'b0;
      ad = ad || ta;
      wd = wd || tw;
    end
    do @(negedge clk); while (b_valid !== 1'b1);
    r = b_resp;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ar_addr <= a;
    ar_valid <= 1'b1;
    do @(negedge clk); while (ar_ready !== 1'b1);
    @(posedge clk);
    ar_valid <= 1'b0;
    do @(negedge clk); while (r_valid !== 1'b1);
    d = r_data;
    r = r_resp;
    @(posedge clk);
  endtask : rd
  task automatic do_reset(input logic f);
    rst <= 1'b1;
    fuse <= f;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic set_div(input logic [3:0] d);
    wr(8'h00, 8'h80, resp);
    chk(32'(irq_blk), 32'h1);
    wr(8'h00, {4'h0, d}, resp);
    chk(32'(irq_blk), 32'h0);
    rd(8'h00, rdat, resp);
    chk(rdat, {28'h0, d});
  endtask : set_div
  // kind bits spread over three registers, then one sleep instruction pulse
  task automatic enter(input logic [2:0] k, input logic arm);
    wr(8'h04, {2'h0, arm, k[1], 4'h0}, resp);
    wr(8'h08, {2'h0, k[2], 5'h00}, resp);
    wr(8'h0C, {k[0], 7'h00}, resp);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    @(negedge clk);
  endtask : enter
  initial begin
    do_reset(1'b1);
    rd(8'h00, rdat, resp);
    chk(rdat, 32'h03);
    for (int a = 1; a < 4; a++) begin
      rd(8'(a * 4), rdat, resp);
      chk(rdat, 32'h00);
    end
    // locked, late, malformed unlock, reserved code, bits 6..4
    wr(8'h00, 8'h05, resp);
    wr(8'h00, 8'h80, resp);
    repeat (6) @(posedge clk);
    wr(8'h00, 8'h05, resp);
    wr(8'h00, 8'h81, resp);
    wr(8'h00, 8'h05, resp);
    wr(8'h00, 8'h80, resp);
    wr(8'h00, 8'h09, resp);
    rd(8'h00, rdat, resp);
    chk(rdat, 32'h03);
    wr(8'h00, 8'h80, resp);
    wr(8'h00, 8'h71, resp);
    rd(8'h00, rdat, resp);
    chk(rdat, 32'h01);
    wr(8'h14, 8'h01, resp);
    chk(32'(resp), 32'h2);
    rd(8'h14, rdat, resp);
    chk({rdat[29:0], resp}, 32'h2);
    // every legal code: count enables over a whole number of periods
    for (int c = 0; c <= 8; c++) begin
      set_div(4'(c));
      tmr_async <= c[0];
      repeat (256) @(posedge clk);
      n_cpu = 0;
      n_io = 0;
      n_asy = 0;
      repeat (512) begin
        @(negedge clk);
        n_cpu += int'(cpu_en === 1'b1);
        n_io += int'(io_en === 1'b1);
        n_asy += int'(asy_en === 1'b1);
      end
      @(posedge clk);
      chk(n_cpu, 512 >> c);
      chk(n_io, 512 >> c);
      chk(n_asy, c[0] ? 512 : 512 >> c);
    end
    set_div(4'h0);
    enter(3'h1, 1'b1);
    chk(32'(sleeping), 32'h0);
    // enter ends on a falling edge; bus requests start after a rising one
    @(posedge clk);
    enter(3'h0, 1'b0);
    chk(32'(sleeping), 32'h0);
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      enter(kinds[i], 1'b1);
      chk({cpu_en, io_en, osc_en, sleeping}, {1'b0, i == 0, i != 1 && i != 2, 1'b1});
      @(posedge clk);
      irq <= 1'b1;
      n_cpu = 0;
      do begin
        @(negedge clk);
        n_cpu++;
      end while (wake_irq !== 1'b1 && n_cpu < 40);
      @(posedge clk);
      irq <= 1'b0;
      chk(n_cpu, waits[i] + 2);
      @(negedge clk);
      chk({wake_irq, sleeping}, 32'h0);
      @(posedge clk);
      rd(8'h04, rdat, resp);
      chk(rdat, {26'h0, 1'b1, kinds[i][1], 4'h0});
    end
    // unlock during idle sleep: the wake must wait for the window to close
    enter(3'h0, 1'b1);
    @(posedge clk);
    wr(8'h00, 8'h80, resp);
    irq <= 1'b1;
    repeat (2) @(negedge clk);
    chk({irq_blk, sleeping}, 32'h3);
    repeat (12) @(posedge clk);
    irq <= 1'b0;
    chk(32'(sleeping), 32'h0);
    enter(3'h0, 1'b1);
    @(posedge clk);
    do_reset(1'b0);
    @(negedge clk);
    chk({wake_irq, sleeping}, 32'h0);
    @(posedge clk);
    rd(8'h00, rdat, resp);
    chk(rdat, 32'h00);
    report_and_stop();
  end
endmodule : clock_prescale_sleep_ctrl_tb
`default_nettype wire
